/* rtl/gcc_map.vh */
// Register map, reset values and timing constants for the output/clock config bank
`ifndef GCC_MAP_VH
`define GCC_MAP_VH
`define GCC_ADDR_OUT_CTRL     8'h12
`define GCC_ADDR_DEV_CFG      8'h13
`define GCC_ADDR_CLK_CTRL     8'h14
`define GCC_RST_OUT_CTRL      8'h77
`define GCC_RST_DEV_CFG       8'h06
`define GCC_RST_CLK_CTRL      8'h01
`define GCC_OUT_CTRL_WMASK    8'h77
`define GCC_CLK_CTRL_WMASK    8'hFF
`define GCC_OC_A_LEVEL        0
`define GCC_OC_A_GATING       1
`define GCC_OC_A_OD           2
`define GCC_OC_B_LEVEL        4
`define GCC_OC_B_GATING       5
`define GCC_OC_B_OD           6
`define GCC_CF_SPREAD         0
`define GCC_CF_THERM          1
`define GCC_CF_ENABLE_PIN_PULLDOWN          2
`define GCC_CF_CLK_PD         3
`define GCC_CF_PIN_FUNC       4
`define GCC_CF_SHUT_RANGE     5
`define GCC_CF_START_RANGE    6
`define GCC_CC_PLL_EN         6
`define GCC_CC_FREQ_HI        4
`define GCC_CC_MAX_FREQ       5'h17
`define GCC_CLK_PERIOD_NS     10
`define GCC_STEP_TIME_NS      500000
`define GCC_STEP_CYCLES       (`GCC_STEP_TIME_NS / `GCC_CLK_PERIOD_NS)
`define GCC_CLK_LOSS_NS       2000
`define GCC_CLK_LOSS_CYCLES   (`GCC_CLK_LOSS_NS / `GCC_CLK_PERIOD_NS)
`endif

/* rtl/gcc_edge_delay.v */
// Delays the rising and falling edges of a level by programmed step counts
`timescale 1ns/1ps
module gcc_edge_delay (
    input  wire       core_clk_i,
    input  wire       rst_n_i,
    input  wire       level_i,
    input  wire       half_tick_i,
    input  wire       start_range_i,
    input  wire       shut_range_i,
    input  wire [3:0] start_code_i,
    input  wire [3:0] shut_code_i,
    output wire       level_o
);
    reg        level_r;
    reg        target_r;
    reg  [4:0] count_r;
    reg  [4:0] load_v;

    assign level_o = level_r;

    // Half-step ticks per code unit: doubled in the long range
    function [4:0] gcc_ticks;
        input [3:0] code;
        input       long_range;
        begin
            gcc_ticks = long_range ? {code, 1'b0} : {1'b0, code};
        end
    endfunction

    always @* begin
        load_v = level_i ? gcc_ticks(start_code_i, start_range_i)
                         : gcc_ticks(shut_code_i, shut_range_i);
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            level_r  <= 1'b0;
            target_r <= 1'b0;
            count_r  <= 5'h00;
        end else if (level_i != target_r) begin
            // New edge restarts timing; zero code passes at once
            target_r <= level_i;
            count_r  <= load_v;
            if (load_v == 5'h00) begin
                level_r <= level_i;
            end
        end else if (level_r != target_r) begin
            if (count_r == 5'h00) begin
                level_r <= target_r;
            end else if (half_tick_i) begin
                count_r <= count_r - 5'h01;
                if (count_r == 5'h01) begin
                    level_r <= target_r;
                end
            end
        end
    end
endmodule

/* rtl/gcc_regs.v */
// General output, device configuration and clock source control register bank
`timescale 1ns/1ps
`include "gcc_map.vh"
module gcc_regs #(
    parameter STEP_CYCLES = `GCC_STEP_CYCLES,
    parameter LOSS_CYCLES = `GCC_CLK_LOSS_CYCLES
) (
    input  wire       core_clk_i,
    input  wire       rst_n_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output wire [7:0] reg_rdata_o,
    input  wire       enable_pin_i,
    input  wire       external_clock_pin_i,
    input  wire [3:0] out_a_start_code_i,
    input  wire [3:0] out_a_shut_code_i,
    input  wire [3:0] out_b_start_code_i,
    input  wire [3:0] out_b_shut_code_i,
    output wire       general_output_a_o,
    output wire       general_output_a_oe_o,
    output wire       general_output_b_o,
    output wire       general_output_b_oe_o,
    output wire       ext_clock_pin_pulldown_o,
    output wire       enable_pin_pulldown_o,
    output wire       thermal_warning_threshold_o,
    output wire       spread_spectrum_on_o,
    output wire       start_range_long_o,
    output wire       shut_range_long_o,
    output wire       pll_enable_o,
    output wire       use_external_clock_o,
    output wire       ext_clock_present_o,
    output wire       ext_clock_event_o,
    output wire [4:0] external_clock_freq_code_o,
    output wire       freq_code_invalid_o
);
    reg  [7:0]  out_ctrl_r;
    reg  [7:0]  dev_cfg_r;
    reg  [7:0]  clk_ctrl_r;
    reg  [7:0]  rdata_r;
    reg  [7:0]  rdata_nxt;
    reg  [2:0]  en_sync_r;
    reg         en_level_r;
    reg  [2:0]  ck_sync_r;
    reg  [31:0] tick_cnt_r;
    reg         half_tick_r;
    reg  [31:0] loss_cnt_r;
    reg         present_r;
    reg         event_r;
    reg         a_oe_r;
    reg         a_out_r;
    reg         b_oe_r;
    reg         b_out_r;
    wire        a_delayed;
    wire        b_delayed;
    wire        a_value;
    wire        b_value;
    wire        ck_edge;

    // Registers steering the block
    wire a_level   = out_ctrl_r[`GCC_OC_A_LEVEL];
    wire a_gating  = out_ctrl_r[`GCC_OC_A_GATING];
    wire a_od      = out_ctrl_r[`GCC_OC_A_OD];
    wire b_level   = out_ctrl_r[`GCC_OC_B_LEVEL];
    wire b_gating  = out_ctrl_r[`GCC_OC_B_GATING];
    wire b_od      = out_ctrl_r[`GCC_OC_B_OD];
    wire pin_clock = dev_cfg_r[`GCC_CF_PIN_FUNC];
    wire pll_en    = clk_ctrl_r[`GCC_CC_PLL_EN];

    // Register writes
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            out_ctrl_r <= `GCC_RST_OUT_CTRL;
            dev_cfg_r  <= `GCC_RST_DEV_CFG;
            clk_ctrl_r <= `GCC_RST_CLK_CTRL;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `GCC_ADDR_OUT_CTRL: out_ctrl_r <= reg_wdata_i & `GCC_OUT_CTRL_WMASK;
                `GCC_ADDR_DEV_CFG:  dev_cfg_r  <= reg_wdata_i;
                `GCC_ADDR_CLK_CTRL: clk_ctrl_r <= reg_wdata_i & `GCC_CLK_CTRL_WMASK;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped addresses read zero
    always @* begin
        case (reg_addr_i)
            `GCC_ADDR_OUT_CTRL: rdata_nxt = out_ctrl_r;
            `GCC_ADDR_DEV_CFG:  rdata_nxt = dev_cfg_r;
            `GCC_ADDR_CLK_CTRL: rdata_nxt = clk_ctrl_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // Pin synchronisers; an enable pin change counts once stages two and three agree, a clock pin edge once they differ
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            en_sync_r  <= 3'h0;
            en_level_r <= 1'b0;
            ck_sync_r  <= 3'h0;
        end else begin
            en_sync_r <= {en_sync_r[1:0], enable_pin_i};
            ck_sync_r <= {ck_sync_r[1:0], external_clock_pin_i};
            if (en_sync_r[1] == en_sync_r[2]) begin
                en_level_r <= en_sync_r[2];
            end
        end
    end

    // Half-millisecond step enable
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tick_cnt_r  <= 32'h0;
            half_tick_r <= 1'b0;
        end else if (tick_cnt_r == STEP_CYCLES - 1) begin
            tick_cnt_r  <= 32'h0;
            half_tick_r <= 1'b1;
        end else begin
            tick_cnt_r  <= tick_cnt_r + 32'h1;
            half_tick_r <= 1'b0;
        end
    end

    gcc_edge_delay u_delay_a (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .level_i       (en_level_r),
        .half_tick_i   (half_tick_r),
        .start_range_i (dev_cfg_r[`GCC_CF_START_RANGE]),
        .shut_range_i  (dev_cfg_r[`GCC_CF_SHUT_RANGE]),
        .start_code_i  (out_a_start_code_i),
        .shut_code_i   (out_a_shut_code_i),
        .level_o       (a_delayed)
    );

    gcc_edge_delay u_delay_b (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .level_i       (en_level_r),
        .half_tick_i   (half_tick_r),
        .start_range_i (dev_cfg_r[`GCC_CF_START_RANGE]),
        .shut_range_i  (dev_cfg_r[`GCC_CF_SHUT_RANGE]),
        .start_code_i  (out_b_start_code_i),
        .shut_code_i   (out_b_shut_code_i),
        .level_o       (b_delayed)
    );

    assign a_value = a_level & (~a_gating | a_delayed);
    assign b_value = b_level & (~b_gating | b_delayed);

    // Pin drivers: push-pull drives always except output B in clock pin function (released), open-drain only pulls low
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            a_oe_r  <= 1'b0;
            a_out_r <= 1'b0;
            b_oe_r  <= 1'b0;
            b_out_r <= 1'b0;
        end else begin
            a_out_r <= a_od ? 1'b0 : a_value;
            a_oe_r  <= a_od ? ~a_value : 1'b1;
            b_out_r <= (b_od | pin_clock) ? 1'b0 : b_value;
            b_oe_r  <= pin_clock ? 1'b0 : (b_od ? ~b_value : 1'b1);
        end
    end

    assign general_output_a_o    = a_out_r;
    assign general_output_a_oe_o = a_oe_r;
    assign general_output_b_o    = b_out_r;
    assign general_output_b_oe_o = b_oe_r;

    // External clock presence: edges seen within the loss window while the PLL is enabled and the clock pin function is selected
    assign ck_edge = ck_sync_r[1] ^ ck_sync_r[2];

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            loss_cnt_r <= 32'h0;
            present_r  <= 1'b0;
            event_r    <= 1'b0;
        end else if (!pll_en || !pin_clock) begin
            loss_cnt_r <= 32'h0;
            present_r  <= 1'b0;
            event_r    <= 1'b0;
        end else if (ck_edge) begin
            loss_cnt_r <= 32'h0;
            present_r  <= 1'b1;
            event_r    <= ~present_r;
        end else if (loss_cnt_r == LOSS_CYCLES - 1) begin
            present_r  <= 1'b0;
            event_r    <= present_r;
        end else begin
            loss_cnt_r <= loss_cnt_r + 32'h1;
            event_r    <= 1'b0;
        end
    end

    assign ext_clock_present_o         = present_r;
    assign ext_clock_event_o           = event_r;
    assign pll_enable_o                = pll_en;
    assign use_external_clock_o        = pll_en & present_r;
    assign external_clock_freq_code_o  = clk_ctrl_r[`GCC_CC_FREQ_HI:0];
    assign freq_code_invalid_o         = clk_ctrl_r[`GCC_CC_FREQ_HI:0] > `GCC_CC_MAX_FREQ;
    assign ext_clock_pin_pulldown_o    = dev_cfg_r[`GCC_CF_CLK_PD];
    assign enable_pin_pulldown_o       = dev_cfg_r[`GCC_CF_ENABLE_PIN_PULLDOWN];
    assign thermal_warning_threshold_o = dev_cfg_r[`GCC_CF_THERM];
    assign spread_spectrum_on_o        = dev_cfg_r[`GCC_CF_SPREAD];
    assign start_range_long_o          = dev_cfg_r[`GCC_CF_START_RANGE];
    assign shut_range_long_o           = dev_cfg_r[`GCC_CF_SHUT_RANGE];
endmodule

/* tb/gcc_regs_checker.sv */
// Port assertions for the output and clock config bank
`timescale 1ns/1ps
module gcc_regs_checker #(
    parameter STEP_CYCLES = 10,
    parameter LOSS_CYCLES = 20
) (
    input wire       core_clk_i,
    input wire       rst_n_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire       general_output_a_o,
    input wire       general_output_a_oe_o,
    input wire       general_output_b_o,
    input wire       general_output_b_oe_o,
    input wire       ext_clock_pin_pulldown_o,
    input wire       enable_pin_pulldown_o,
    input wire       thermal_warning_threshold_o,
    input wire       spread_spectrum_on_o,
    input wire       start_range_long_o,
    input wire       shut_range_long_o,
    input wire       pll_enable_o,
    input wire       use_external_clock_o,
    input wire       ext_clock_present_o,
    input wire       ext_clock_event_o,
    input wire [4:0] external_clock_freq_code_o,
    input wire       freq_code_invalid_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_cfg_follow: assert property (
        reg_wr_i && reg_addr_i == 8'h13 |=> {start_range_long_o, shut_range_long_o,
        ext_clock_pin_pulldown_o, enable_pin_pulldown_o, thermal_warning_threshold_o,
        spread_spectrum_on_o} == {$past(reg_wdata_i[6:5]), $past(reg_wdata_i[3:0])})
        else $error("config outputs do not follow write");
    a_clk_follow: assert property (
        reg_wr_i && reg_addr_i == 8'h14 |=> pll_enable_o == $past(reg_wdata_i[6])
        && external_clock_freq_code_o == $past(reg_wdata_i[4:0]))
        else $error("clock control outputs do not follow write");
    a_reserved_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h12 |-> ##2 (reg_rdata_o & 8'h88) == 8'h00)
        else $error("reserved output control bits read nonzero");
    a_freq_invalid: assert property (
        $stable(external_clock_freq_code_o) |->
        freq_code_invalid_o == (external_clock_freq_code_o > 5'h17))
        else $error("invalid frequency flag wrong");
    a_pll_off: assert property (
        !pll_enable_o [*2] |-> !use_external_clock_o && !ext_clock_present_o)
        else $error("external clock used while pll off");
    a_use_ext: assert property (
        (ext_clock_present_o && pll_enable_o) [*2] |-> use_external_clock_o)
        else $error("present external clock not used");
    a_event_change: assert property (
        ext_clock_event_o |-> $changed(ext_clock_present_o))
        else $error("clock event without presence change");
    a_event_pulse: assert property (
        ext_clock_event_o |=> !ext_clock_event_o)
        else $error("clock event longer than one cycle");
    a_od_a_low: assert property (
        !general_output_a_oe_o |-> !general_output_a_o)
        else $error("output a high while not driven");
    a_od_b_low: assert property (
        !general_output_b_oe_o |-> !general_output_b_o)
        else $error("output b high while not driven");
    c_appear: cover property (ext_clock_event_o && ext_clock_present_o);
    c_vanish: cover property (ext_clock_event_o && !ext_clock_present_o);
    c_a_high: cover property (general_output_a_o && general_output_a_oe_o);
endmodule

bind gcc_regs gcc_regs_checker #(.STEP_CYCLES(STEP_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) chk_i (
    .core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .general_output_a_o, .general_output_a_oe_o, .general_output_b_o, .general_output_b_oe_o,
    .ext_clock_pin_pulldown_o, .enable_pin_pulldown_o, .thermal_warning_threshold_o,
    .spread_spectrum_on_o, .start_range_long_o, .shut_range_long_o, .pll_enable_o,
    .use_external_clock_o, .ext_clock_present_o, .ext_clock_event_o,
    .external_clock_freq_code_o, .freq_code_invalid_o);

/* tb/gcc_clk_src.sv */
// External clock source for the shared clock pin
`timescale 1ns/1ps
module gcc_clk_src #(
    parameter HALF = 3
) (
    input  wire core_clk_i,
    input  wire run_i,
    output reg  pin_o
);
    integer cnt;
    initial begin
        pin_o = 1'b0;
        cnt = 0;
    end
    always @(posedge core_clk_i) begin
        cnt <= (cnt + 1) % HALF;
        // Stopped source leaves the pin at its pull-down level
        if (!run_i)
            pin_o <= 1'b0;
        else if (cnt == 0)
            pin_o <= ~pin_o;
    end
endmodule

/* tb/gcc_regs_test.sv */
// Self-checking bench for the output and clock config bank
`timescale 1ns/1ps
module gcc_regs_test;
    localparam STEP = 10;
    localparam LOSS = 20;
    logic       clk, rst_n, wr, rd, en, run;
    logic [7:0] addr, wdata;
    logic [3:0] a_st, a_sh;
    wire  [7:0] rdata;
    wire        oa, oa_oe, ob, ob_oe, pin, use_x, pres, evt, inv;
    wire  [2:0] mon = {evt, ob, oa};
    int         failures, checks_done, cyc, n;
    logic [7:0] ctl [5] = '{8'h11, 8'h00, 8'h55, 8'h44, 8'h33};
    logic [3:0] ex  [5] = '{4'hF, 4'h5, 4'h0, 4'h5, 4'h5};
    gcc_regs #(.STEP_CYCLES(STEP), .LOSS_CYCLES(LOSS)) DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .enable_pin_i(en), .external_clock_pin_i(pin),
        .out_a_start_code_i(a_st), .out_a_shut_code_i(a_sh),
        .out_b_start_code_i(4'h0), .out_b_shut_code_i(4'h0),
        .general_output_a_o(oa), .general_output_a_oe_o(oa_oe),
        .general_output_b_o(ob), .general_output_b_oe_o(ob_oe),
        .ext_clock_pin_pulldown_o(), .enable_pin_pulldown_o(),
        .thermal_warning_threshold_o(), .spread_spectrum_on_o(),
        .start_range_long_o(), .shut_range_long_o(), .pll_enable_o(),
        .use_external_clock_o(use_x), .ext_clock_present_o(pres),
        .ext_clock_event_o(evt), .external_clock_freq_code_o(),
        .freq_code_invalid_o(inv));
    gcc_clk_src src (.core_clk_i(clk), .run_i(run), .pin_o(pin));
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    task automatic wait_on(input int sel, input logic v, output int k);
        k = 0;
        while (k < 200 && mon[sel] !== v) begin
            @(negedge clk);
            k++;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        {rst_n, wr, rd, en, run, addr, wdata} = '0;
        a_st = 4'h3;
        a_sh = 4'h3;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(8'h12, 8'h77);
        rd_reg(8'h13, 8'h06);
        rd_reg(8'h14, 8'h01);
        rd_reg(8'h15, 8'h00);
        wr_reg(8'h12, 8'hFF);
        rd_reg(8'h12, 8'h77);
        for (int i = 0; i < 5; i++) begin
            rd_reg(8'h13, 8'h06);
            wr_reg(8'h12, ctl[i]);
            chk({ob, ob_oe, oa, oa_oe}, ex[i]);
        end
        for (int r = 0; r < 2; r++) begin
            wr_reg(8'h13, {1'b0, r[0], r[0], 5'h06});
            en = 1'b1;
            wait_on(0, 1'b1, n);
            chk(n >= 30 * (r + 1) - 10 && n <= 30 * (r + 1) + 18, 1'b1);
            chk(ob, 1'b1);
            en = 1'b0;
            wait_on(0, 1'b0, n);
            chk(n >= 30 * (r + 1) - 10 && n <= 30 * (r + 1) + 18, 1'b1);
            chk(ob, 1'b0);
        end
        wr_reg(8'h12, 8'h32);
        en = 1'b1;
        repeat (60) @(negedge clk);
        chk(oa, 1'b0);
        wr_reg(8'h12, 8'h11);
        wr_reg(8'h13, 8'h16);
        chk({ob, ob_oe}, 2'b00);
        wr_reg(8'h14, 8'h41);
        run = 1'b1;
        wait_on(2, 1'b1, n);
        @(negedge clk);
        chk({pres, use_x, n < 20}, 3'b111);
        run = 1'b0;
        wait_on(2, 1'b1, n);
        chk({pres, n <= LOSS + 10}, 2'b01);
        wr_reg(8'h14, 8'h01);
        run = 1'b1;
        repeat (40) @(negedge clk);
        chk({pres, use_x, evt}, 3'b000);
        run = 1'b0;
        wr_reg(8'h14, 8'h18);
        chk(inv, 1'b1);
        wr_reg(8'h14, 8'h17);
        chk(inv, 1'b0);
        summarize();
    end
endmodule
